//--- rtl/sff_ctrl.sv
// Design decisions made here: the address map and register access over Avalon-MM.
`default_nettype none

module sff_ctrl
  import sff_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Avalon-MM register slave
  input wire logic [5:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // Processor fetch port
  input wire logic fetch_req_i,
  input wire logic [16:0] fetch_addr_i,
  input wire logic fetch_space_i,
  output logic fetch_ready_o,
  output logic [7:0] fetch_data_o,
  // Boot result
  output logic boot_done_o,
  output logic boot_from_flash_o,
  output logic [16:0] boot_vector_o,
  // Strap and flash pins
  input wire logic serial_rate_strap_i,
  output logic flash_select_b_o,
  output logic flash_clock_o,
  output logic flash_data_out_o,
  output logic flash_data_out_oe_o,
  input wire logic flash_data_io0_i,
  input wire logic flash_serial_in_i
);

  typedef struct packed {
    sff_state_t st;
    logic cs_b;
    logic burst;
    logic bdual;
    logic cspace;
    logic [16:0] addr;
    logic [16:0] base;
    logic [5:0] len;
    logic [31:0][7:0] cache;
    logic [2:0] hdr;
    logic [3:0] idx;
    logic wait_sh;
    logic sh_start;
    logic sh_dual;
    logic [7:0] sh_tx;
    logic rdy;
    logic [7:0] fdata;
    logic boot_act;
    logic [2:0] boot_cnt;
    logic boot_ok;
    logic img_valid;
    logic go;
    logic dual_en;
    logic flash_off;
    logic [7:0] fr_op;
    logic [3:0] xlen;
    logic [7:0][7:0] cmd;
    logic [7:0][7:0] resp;
    logic rd_ok;
    logic [31:0] rdata;
    logic strap_m;
    logic strap_s;
    logic [1:0] strap_cnt;
    logic fast;
  } sff_ctrl_state_t;

  sff_ctrl_state_t r_reg;
  sff_ctrl_state_t r_next;
  sff_shift_if sif ();

  logic strap_done;
  logic req_v;
  logic [16:0] req_addr;
  logic req_space;
  logic seq;
  logic hit;
  logic [16:0] diff;
  logic dlv;
  logic [7:0] dbyte;
  logic [3:0] resp_idx;
  logic busy;

  assign strap_done = (r_reg.strap_cnt == STRAP_LATCH_CYC);
  assign req_v = strap_done & (r_reg.boot_act | (fetch_req_i & ~r_reg.rdy));
  assign req_addr = r_reg.boot_act ? 17'(BOOT_SIG_ADDR + {14'h0000, r_reg.boot_cnt})
                                   : fetch_addr_i;
  assign req_space = r_reg.boot_act ? 1'b0 : fetch_space_i;
  assign seq = r_reg.burst & (req_space == r_reg.cspace) &
               (req_addr == 17'(r_reg.addr + 17'h00001));
  assign diff = 17'(req_addr - r_reg.base);
  assign hit = (req_space == r_reg.cspace) & (diff < {11'h000, r_reg.len});
  assign resp_idx = r_reg.idx - 4'h1;
  assign busy = r_reg.go | (r_reg.st == ST_CMD);

  always_comb begin
    r_next = r_reg;
    r_next.sh_start = 1'b0;
    r_next.rdy = 1'b0;
    dlv = 1'b0;
    dbyte = sif.rx;

    // The strap is caught once its synchroniser has filled after reset.
    r_next.strap_m = serial_rate_strap_i;
    r_next.strap_s = r_reg.strap_m;
    if (!strap_done) begin
      r_next.strap_cnt = r_reg.strap_cnt + 2'h1;
      r_next.fast = r_reg.strap_s;
    end

    // Writes land at the edge where write is seen.
    if (avs_write_i) begin
      case (avs_address_i)
        OFF_CTRL: begin
          if (avs_byteenable_i[0]) begin
            r_next.dual_en = avs_writedata_i[CTRL_DUAL_BIT];
            if (avs_writedata_i[CTRL_GO_BIT] && !r_reg.flash_off) begin
              r_next.go = 1'b1;
            end
          end
        end
        OFF_UTIL: begin
          if (avs_byteenable_i[0]) begin
            r_next.flash_off = avs_writedata_i[UTIL_OFF_BIT];
          end
        end
        OFF_FROP: begin
          if (avs_byteenable_i[0]) begin
            r_next.fr_op = avs_writedata_i[7:0];
          end
        end
        OFF_LEN: begin
          if (avs_byteenable_i[0]) begin
            r_next.xlen = avs_writedata_i[3:0];
          end
        end
        OFF_CMD0: r_next.cmd[3:0] = sff_merge(r_reg.cmd[3:0], avs_writedata_i, avs_byteenable_i);
        OFF_CMD1: r_next.cmd[7:4] = sff_merge(r_reg.cmd[7:4], avs_writedata_i, avs_byteenable_i);
        default: begin
        end
      endcase
    end

    // Reads wait one cycle: data is captured, then waitrequest drops.
    r_next.rd_ok = avs_read_i & ~r_reg.rd_ok;
    if (avs_read_i && !r_reg.rd_ok) begin
      case (avs_address_i)
        OFF_CTRL: r_next.rdata = {30'h00000000, r_reg.dual_en, r_reg.go};
        OFF_UTIL: r_next.rdata = {31'h00000000, r_reg.flash_off};
        OFF_FROP: r_next.rdata = {24'h000000, r_reg.fr_op};
        OFF_LEN: r_next.rdata = {28'h0000000, r_reg.xlen};
        OFF_CMD0: r_next.rdata = r_reg.cmd[3:0];
        OFF_CMD1: r_next.rdata = r_reg.cmd[7:4];
        OFF_RSP0: r_next.rdata = r_reg.resp[3:0];
        OFF_RSP1: r_next.rdata = r_reg.resp[7:4];
        OFF_STAT: r_next.rdata = {27'h0000000, r_reg.fast, r_reg.burst, r_reg.img_valid,
                                  ~r_reg.boot_act, busy};
        default: r_next.rdata = 32'h00000000;
      endcase
    end

    case (r_reg.st)
      ST_IDLE: begin
        if (r_reg.burst && (r_reg.flash_off || (r_reg.go && !r_reg.boot_act))) begin
          r_next.cs_b = 1'b1;
          r_next.burst = 1'b0;
          r_next.st = ST_GAP;
        end else if (r_reg.go && !r_reg.boot_act) begin
          if (r_reg.xlen == 4'h0 || r_reg.flash_off) begin
            r_next.go = 1'b0;
          end else begin
            r_next.cs_b = 1'b0;
            r_next.idx = 4'h0;
            r_next.wait_sh = 1'b0;
            r_next.st = ST_CMD;
          end
        end else if (req_v) begin
          if (r_reg.flash_off && !r_reg.boot_act) begin
            // A disabled interface still answers so that the processor cannot hang.
            dlv = 1'b1;
            dbyte = DONT_CARE_BYTE;
          end else if (seq) begin
            r_next.addr = req_addr;
            r_next.wait_sh = 1'b0;
            r_next.st = ST_DATA;
          end else if (r_reg.burst) begin
            r_next.cs_b = 1'b1;
            r_next.burst = 1'b0;
            r_next.st = ST_GAP;
          end else if (hit) begin
            dlv = 1'b1;
            dbyte = r_reg.cache[req_addr[4:0]];
          end else begin
            r_next.base = req_addr;
            r_next.len = 6'h00;
            r_next.cspace = req_space;
            r_next.addr = req_addr;
            r_next.bdual = r_reg.dual_en & req_space;
            r_next.burst = 1'b1;
            r_next.cs_b = 1'b0;
            r_next.hdr = 3'h0;
            r_next.wait_sh = 1'b0;
            r_next.st = ST_HDR;
          end
        end
      end
      ST_HDR: begin
        if (!r_reg.wait_sh) begin
          r_next.sh_start = 1'b1;
          r_next.wait_sh = 1'b1;
          r_next.sh_dual = 1'b0;
          case (r_reg.hdr)
            3'h0: r_next.sh_tx = r_reg.bdual ? r_reg.fr_op : OP_FAST_READ;
            3'h1: r_next.sh_tx = {7'h00, r_reg.addr[16]};
            3'h2: r_next.sh_tx = r_reg.addr[15:8];
            3'h3: r_next.sh_tx = r_reg.addr[7:0];
            default: r_next.sh_tx = DONT_CARE_BYTE;
          endcase
        end else if (sif.done) begin
          r_next.wait_sh = 1'b0;
          r_next.hdr = r_reg.hdr + 3'h1;
          if (r_reg.hdr == HDR_LAST) begin
            r_next.st = ST_DATA;
          end
        end
      end
      ST_DATA: begin
        if (!r_reg.wait_sh) begin
          r_next.sh_start = 1'b1;
          r_next.wait_sh = 1'b1;
          r_next.sh_dual = r_reg.bdual;
          r_next.sh_tx = DONT_CARE_BYTE;
        end else if (sif.done) begin
          r_next.wait_sh = 1'b0;
          r_next.cache[r_reg.addr[4:0]] = sif.rx;
          if (r_reg.len == CACHE_BYTES) begin
            r_next.base = 17'(r_reg.base + 17'h00001);
          end else begin
            r_next.len = r_reg.len + 6'h01;
          end
          dlv = 1'b1;
          r_next.st = ST_IDLE;
        end
      end
      ST_GAP: begin
        r_next.st = ST_IDLE;
      end
      ST_CMD: begin
        if (!r_reg.wait_sh) begin
          r_next.sh_start = 1'b1;
          r_next.wait_sh = 1'b1;
          r_next.sh_dual = 1'b0;
          r_next.sh_tx = (r_reg.idx < BUF_BYTES) ? r_reg.cmd[r_reg.idx[2:0]]
                                                 : DONT_CARE_BYTE;
        end else if (sif.done) begin
          r_next.wait_sh = 1'b0;
          if (r_reg.idx != 4'h0 && resp_idx < BUF_BYTES) begin
            r_next.resp[resp_idx[2:0]] = sif.rx;
          end
          r_next.idx = r_reg.idx + 4'h1;
          if (r_reg.idx + 4'h1 == r_reg.xlen) begin
            r_next.cs_b = 1'b1;
            r_next.go = 1'b0;
            r_next.st = ST_GAP;
          end
        end
      end
      default: begin
        r_next.cs_b = 1'b1;
        r_next.burst = 1'b0;
        r_next.st = ST_IDLE;
      end
    endcase

    if (dlv) begin
      if (r_reg.boot_act) begin
        if (dbyte != IMG_SIG[r_reg.boot_cnt]) begin
          r_next.boot_ok = 1'b0;
        end
        r_next.boot_cnt = r_reg.boot_cnt + 3'h1;
        if (r_reg.boot_cnt == BOOT_SIG_LAST) begin
          r_next.boot_act = 1'b0;
          r_next.img_valid = r_reg.boot_ok & (dbyte == IMG_SIG[r_reg.boot_cnt]);
        end
      end else begin
        r_next.rdy = 1'b1;
        r_next.fdata = dbyte;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      r_reg <= '0;
      r_reg.cs_b <= 1'b1;
      r_reg.boot_act <= 1'b1;
      r_reg.boot_ok <= 1'b1;
      r_reg.fr_op <= FR_OPCODE_RST;
    end else begin
      r_reg <= r_next;
    end
  end

  assign sif.start = r_reg.sh_start;
  assign sif.dual = r_reg.sh_dual;
  assign sif.fast = r_reg.fast;
  assign sif.tx = r_reg.sh_tx;

  sff_shifter u_shifter (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .sif(sif.eng),
    .flash_clock_o(flash_clock_o),
    .flash_data_out_o(flash_data_out_o),
    .flash_data_out_oe_o(flash_data_out_oe_o),
    .flash_data_io0_i(flash_data_io0_i),
    .flash_serial_in_i(flash_serial_in_i)
  );

  // Execution starts at the external base whether or not the signature matched.
  assign boot_vector_o = EXEC_START_ADDR;
  assign boot_done_o = ~r_reg.boot_act;
  assign boot_from_flash_o = r_reg.img_valid;
  assign fetch_ready_o = r_reg.rdy;
  assign fetch_data_o = r_reg.fdata;
  assign flash_select_b_o = r_reg.cs_b;
  assign avs_readdata_o = r_reg.rdata;
  assign avs_waitrequest_o = avs_read_i & ~r_reg.rd_ok;

endmodule : sff_ctrl

`default_nettype wire

//--- rtl/sff_pkg.sv
// Functional notes
// - At power-up check flash for the image signature from 0xFFFA; flag flash boot.
// - Flash interface is enabled after reset until software sets the disable bit.
// - Single fast read drives select low, sends 0x0B, 24-bit address, one dummy.
// - Single-lane data bytes are captured over eight serial clocks after the dummy.
// - After a full byte arrives, pulse ready to the processor with the byte.
// - Address equal to previous plus one keeps the burst open and reads on.
// - Any other address ends the burst by driving select high.
// - Dual reads of external data space send the programmable opcode; software loads 0x3B.
// - Dual mode address bits 23..17 are zero, bits 16..0 come from the bus.
// - Dual data bytes take four serial clocks, two bits per clock.
// - Fetch path keeps a 32-byte cache with base and length; jumps reload base.
// - Sequential bytes fill the cache; past 32 bytes the base advances.
// - A jump into the cached range is served without flash access, in one clock once any open burst has been closed.
// - Command mode has 8-byte command and response buffers and a byte length.
// - Self-clearing go bit asserts select and gives exactly length times 8 clocks.
// - Command mode stores input bits into responses after the first command byte.
// - Lengths beyond the command buffer send don't-care bytes on data out.
// - Identification read uses 0x9F, length 4; three response bytes, select released.
// - Serial rate follows a strap latched after reset; low is the slower default.
`default_nettype none

package sff_pkg;

  localparam logic [7:0] OP_FAST_READ = 8'h0B;
  localparam logic [7:0] FR_OPCODE_RST = 8'h00;
  localparam logic [7:0] DONT_CARE_BYTE = 8'hFF;
  localparam logic [16:0] BOOT_SIG_ADDR = 17'h0FFFA;
  localparam logic [16:0] EXEC_START_ADDR = 17'h00000;
  localparam logic [2:0] BOOT_SIG_LAST = 3'h5;
  // Arbitrary signature; byte k sits at BOOT_SIG_ADDR + k.
  localparam logic [5:0][7:0] IMG_SIG = 48'h69_96_3C_C3_A5_5A;

  // Fetch header: opcode, three address bytes, one dummy byte.
  localparam logic [2:0] HDR_LAST = 3'h4;
  localparam logic [5:0] CACHE_BYTES = 6'h20;
  localparam logic [3:0] BUF_BYTES = 4'h8;

  // Register byte offsets on the Avalon slave.
  localparam logic [5:0] OFF_CTRL = 6'h00;
  localparam logic [5:0] OFF_UTIL = 6'h04;
  localparam logic [5:0] OFF_FROP = 6'h08;
  localparam logic [5:0] OFF_LEN = 6'h0C;
  localparam logic [5:0] OFF_CMD0 = 6'h10;
  localparam logic [5:0] OFF_CMD1 = 6'h14;
  localparam logic [5:0] OFF_RSP0 = 6'h18;
  localparam logic [5:0] OFF_RSP1 = 6'h1C;
  localparam logic [5:0] OFF_STAT = 6'h20;

  localparam int CTRL_GO_BIT = 0;
  localparam int CTRL_DUAL_BIT = 1;
  localparam int UTIL_OFF_BIT = 0;

  // Serial clock half periods in core cycles for slow and fast strap settings.
  localparam logic [1:0] HALF_SLOW = 2'h2;
  localparam logic [1:0] HALF_FAST = 2'h1;
  localparam logic [1:0] STRAP_LATCH_CYC = 2'h3;
  localparam logic [3:0] BITS_SINGLE = 4'h8;
  localparam logic [3:0] BITS_DUAL = 4'h4;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_HDR = 3'b001,
    ST_DATA = 3'b010,
    ST_GAP = 3'b011,
    ST_CMD = 3'b100
  } sff_state_t;

  function automatic logic [31:0] sff_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                            input logic [3:0] be);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return res;
  endfunction : sff_merge

endpackage : sff_pkg

`default_nettype wire

//--- rtl/sff_shift_if.sv
`default_nettype none

interface sff_shift_if;
  logic start;
  logic dual;
  logic fast;
  logic [7:0] tx;
  logic done;
  logic [7:0] rx;

  modport ctl (output start, output dual, output fast, output tx, input done, input rx);
  modport eng (input start, input dual, input fast, input tx, output done, output rx);
endinterface : sff_shift_if

`default_nettype wire

//--- rtl/sff_shifter.sv
`default_nettype none

module sff_shifter
  import sff_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Byte request from the controller
  sff_shift_if.eng sif,
  // Flash pins
  output logic flash_clock_o,
  output logic flash_data_out_o,
  output logic flash_data_out_oe_o,
  input wire logic flash_data_io0_i,
  input wire logic flash_serial_in_i
);

  typedef struct packed {
    logic busy;
    logic done;
    logic dual;
    logic sck;
    logic [1:0] div;
    logic [3:0] bits;
    logic [7:0] sh;
    logic [7:0] rx;
    logic mosi;
    logic oe;
    logic si_m;
    logic si_s;
    logic io0_m;
    logic io0_s;
  } sff_shift_state_t;

  sff_shift_state_t r_reg;
  sff_shift_state_t r_next;
  logic [1:0] half;

  assign half = sif.fast ? HALF_FAST : HALF_SLOW;

  // Pins are read at the falling edge; only at the slow strap setting does the synchroniser then hold the low-phase value.
  always_comb begin
    r_next = r_reg;
    r_next.done = 1'b0;
    r_next.si_m = flash_serial_in_i;
    r_next.si_s = r_reg.si_m;
    r_next.io0_m = flash_data_io0_i;
    r_next.io0_s = r_reg.io0_m;
    if (sif.start) begin
      r_next.busy = 1'b1;
      r_next.dual = sif.dual;
      r_next.sh = sif.tx;
      r_next.bits = sif.dual ? BITS_DUAL : BITS_SINGLE;
      r_next.sck = 1'b0;
      r_next.div = half - 2'h1;
      r_next.mosi = sif.tx[7];
      r_next.oe = ~sif.dual;
    end else if (r_reg.busy) begin
      if (r_reg.div != 2'h0) begin
        r_next.div = r_reg.div - 2'h1;
      end else begin
        r_next.div = half - 2'h1;
        if (!r_reg.sck) begin
          r_next.sck = 1'b1;
        end else begin
          r_next.sck = 1'b0;
          if (r_reg.dual) begin
            r_next.rx = {r_reg.rx[5:0], r_reg.si_s, r_reg.io0_s};
          end else begin
            r_next.rx = {r_reg.rx[6:0], r_reg.si_s};
          end
          r_next.sh = {r_reg.sh[6:0], 1'b0};
          r_next.bits = r_reg.bits - 4'h1;
          r_next.mosi = r_reg.sh[6];
          if (r_reg.bits == 4'h1) begin
            r_next.busy = 1'b0;
            r_next.done = 1'b1;
            r_next.oe = 1'b1;
          end
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      r_reg <= '0;
      r_reg.mosi <= 1'b1;
      r_reg.oe <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  assign sif.done = r_reg.done;
  assign sif.rx = r_reg.rx;
  assign flash_clock_o = r_reg.sck;
  assign flash_data_out_o = r_reg.mosi;
  assign flash_data_out_oe_o = r_reg.oe;

endmodule : sff_shifter

`default_nettype wire

//--- testbench/sff_flash_model.sv
`default_nettype none
// Serial flash model.
module sff_flash_model
  import sff_pkg::*;
#(
  parameter logic [23:0] ID = 24'h3A5C71 // Arbitrary identification value.
) (
  // Flash pins
  input wire logic sel_b_i,
  input wire logic sck_i,
  input wire logic mosi_i,
  output logic miso_o,
  output logic io0_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] rx_b [16];
  logic [7:0] sh;
  logic [7:0] b;
  logic [23:0] a;
  int bc = 0;
  int d;
  int frames = 0;

  function automatic logic [7:0] dat(input logic [23:0] ad);
    if (ad >= 24'h00FFFA && ad <= 24'h00FFFF) return IMG_SIG[ad[2:0] - 3'h2];
    return ad[7:0] ^ 8'hA3;
  endfunction : dat

  initial begin
    miso_o = 1'b0;
    io0_o = 1'b0;
  end

  always @(negedge sel_b_i) begin
    bc = 0;
    frames++;
  end

  always @(posedge sck_i) begin
    sh = {sh[6:0], mosi_i};
    bc++;
    if (bc % 8 == 0 && bc <= 128) rx_b[bc / 8 - 1] = sh;
  end

  // Released lines toggle so a stale bit cannot pass as valid.
  always @(negedge sck_i or posedge sel_b_i) begin
    a = {rx_b[1], rx_b[2], rx_b[3]};
    d = bc - 40;
    if (!sel_b_i && rx_b[0] == 8'h0B && bc >= 40) begin
      b = dat(a + 24'(d / 8));
      miso_o <= b[7 - d % 8];
    end else if (!sel_b_i && rx_b[0] == 8'h3B && bc >= 40) begin
      b = dat(a + 24'(d / 4));
      miso_o <= b[7 - 2 * (d % 4)];
      io0_o <= b[6 - 2 * (d % 4)];
    end else if (!sel_b_i && rx_b[0] == 8'h9F && bc >= 8) begin
      b = ID[8 * (2 - ((bc - 8) / 8) % 3) +: 8];
      miso_o <= b[7 - bc % 8];
    end else begin
      miso_o <= !miso_o;
      io0_o <= !io0_o;
    end
  end
endmodule : sff_flash_model
`default_nettype wire

//--- testbench/sff_assertions.sv
`default_nettype none
module sff_checker (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Register bus and fetch handshake
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic avs_waitrequest_o,
  input wire logic fetch_req_i,
  input wire logic fetch_ready_o,
  // Boot result, strap and flash pins
  input wire logic boot_done_o,
  input wire logic [16:0] boot_vector_o,
  input wire logic serial_rate_strap_i,
  input wire logic flash_select_b_o,
  input wire logic flash_clock_o,
  input wire logic flash_data_out_o,
  input wire logic flash_data_out_oe_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_b_i);

  a_write_no_wait: assert property (avs_write_i |-> !avs_waitrequest_o)
    else $error("write waited");
  a_read_one_wait: assert property (avs_read_i && avs_waitrequest_o
    |=> !avs_waitrequest_o)
    else $error("read answer late");
  a_ready_one_cycle: assert property (fetch_ready_o |=> !fetch_ready_o)
    else $error("ready too long");
  a_ready_with_request: assert property (fetch_ready_o |-> fetch_req_i)
    else $error("stray ready");
  a_select_gap: assert property ($rose(flash_select_b_o) |=> flash_select_b_o)
    else $error("select gap short");
  a_clock_in_frame: assert property (flash_select_b_o && $past(flash_select_b_o)
    |-> !flash_clock_o)
    else $error("clock outside frame");
  a_data_before_edge: assert property ($rose(flash_clock_o)
    |-> $stable(flash_data_out_o))
    else $error("data moved at rise");
  a_drive_when_idle: assert property ($rose(flash_select_b_o) |=> flash_data_out_oe_o)
    else $error("data out released");
  a_slow_half_period: assert property ($rose(flash_clock_o) && !serial_rate_strap_i
    |-> flash_clock_o [*2] ##1 !flash_clock_o)
    else $error("slow high phase wrong");
  a_boot_held: assert property (boot_done_o |=> boot_done_o && boot_vector_o == 17'h00000)
    else $error("boot result changed");

  c_fetch_done: cover property (fetch_req_i && fetch_ready_o);
  c_frame_start: cover property ($fell(flash_select_b_o));
  c_read_answer: cover property (avs_read_i && !avs_waitrequest_o);
  c_dual_data: cover property ($fell(flash_data_out_oe_o));
endmodule : sff_checker

bind sff_ctrl sff_checker sff_checker_i (
  .clk_i(clk_i), .rst_b_i(rst_b_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
  .avs_waitrequest_o(avs_waitrequest_o), .fetch_req_i(fetch_req_i),
  .fetch_ready_o(fetch_ready_o), .boot_done_o(boot_done_o), .boot_vector_o(boot_vector_o),
  .serial_rate_strap_i(serial_rate_strap_i), .flash_select_b_o(flash_select_b_o),
  .flash_clock_o(flash_clock_o), .flash_data_out_o(flash_data_out_o),
  .flash_data_out_oe_o(flash_data_out_oe_o)
);
`default_nettype wire

//--- testbench/spi_flash_fetch_controller_tb.sv
`default_nettype none
module spi_flash_fetch_controller_tb import sff_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  // Erase opcodes, then arbitrary ones.
  localparam logic [0:8][7:0] OPS = {8'h20, 8'h52, 8'hD8, 8'hA1, 8'h5E, 8'h33, 8'hC4, 8'h7B, 8'h19};
  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic [5:0] avs_address_i = 6'h00;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o;
  logic fetch_req_i = 1'b0;
  logic [16:0] fetch_addr_i = 17'h0;
  logic fetch_space_i = 1'b0;
  logic fetch_ready_o, boot_done_o, boot_from_flash_o;
  logic [7:0] fetch_data_o;
  logic [16:0] boot_vector_o;
  logic flash_select_b_o, flash_clock_o, flash_data_out_o, flash_data_out_oe_o;
  logic miso, m_io0, io0;
  int bad_count = 0;
  int compares = 0;

  assign io0 = flash_data_out_oe_o ? flash_data_out_o : m_io0;
  always #12.5 clk_i = ~clk_i;

  sff_ctrl sff_ctrl_i (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(4'hF),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .fetch_req_i(fetch_req_i), .fetch_addr_i(fetch_addr_i), .fetch_space_i(fetch_space_i),
    .fetch_ready_o(fetch_ready_o), .fetch_data_o(fetch_data_o), .boot_done_o(boot_done_o),
    .boot_from_flash_o(boot_from_flash_o), .boot_vector_o(boot_vector_o),
    .serial_rate_strap_i(1'b0), .flash_select_b_o(flash_select_b_o),
    .flash_clock_o(flash_clock_o), .flash_data_out_o(flash_data_out_o),
    .flash_data_out_oe_o(flash_data_out_oe_o), .flash_data_io0_i(io0), .flash_serial_in_i(miso)
  );
  sff_flash_model sff_flash_model_i (
    .sel_b_i(flash_select_b_o), .sck_i(flash_clock_o), .mosi_i(io0), .miso_o(miso), .io0_o(m_io0)
  );

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    @(posedge clk_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= 1'b1;
    do @(posedge clk_i); while (avs_waitrequest_o !== 1'b0);
    avs_write_i <= 1'b0;
  endtask : wr

  task automatic rd(input logic [5:0] a, output logic [31:0] d);
    @(posedge clk_i);
    avs_address_i <= a;
    avs_read_i <= 1'b1;
    do @(posedge clk_i); while (avs_waitrequest_o !== 1'b0);
    d = avs_readdata_o;
    avs_read_i <= 1'b0;
  endtask : rd

  task automatic fetch(input logic [16:0] a, input logic s, output logic [7:0] d, output int n);
    @(posedge clk_i);
    fetch_req_i <= 1'b1;
    fetch_addr_i <= a;
    fetch_space_i <= s;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (fetch_ready_o !== 1'b1);
    d = fetch_data_o;
    fetch_req_i <= 1'b0;
  endtask : fetch

  task automatic fchk(input logic [16:0] a, input logic s, output int n);
    logic [7:0] d;
    fetch(a, s, d, n);
    chk("fetch_data", sff_flash_model_i.dat({7'h0, a}), d);
  endtask : fchk

  task automatic t_boot;
    logic [31:0] r;
    repeat (3000) if (boot_done_o !== 1'b1) @(posedge clk_i);
    chk("boot_flash", 1, boot_from_flash_o);
    chk("boot_vector", 0, boot_vector_o);
    rd(OFF_STAT, r);
    chk("status_boot", 32'h6, r & 32'h6);
    rd(OFF_UTIL, r);
    chk("util_reset", 0, r);
    rd(OFF_FROP, r);
    chk("opcode_reset", FR_OPCODE_RST, r);
    rd(6'h24, r);
    chk("unmapped", 0, r);
  endtask : t_boot

  task automatic t_seq;
    int f, n;
    f = sff_flash_model_i.frames;
    for (int i = 0; i < 3; i++) fchk(17'h00100 + 17'(i), 1'b0, n);
    chk("seq_frames", f + 1, sff_flash_model_i.frames);
    chk("seq_select", 0, flash_select_b_o);
    chk("opcode", OP_FAST_READ, sff_flash_model_i.rx_b[0]);
    chk("address", 32'h100, {sff_flash_model_i.rx_b[2], sff_flash_model_i.rx_b[3]});
    chk("clocks", 64, sff_flash_model_i.bc);
    fchk(17'h00200, 1'b0, n);
    chk("jump_frames", f + 2, sff_flash_model_i.frames);
  endtask : t_seq

  task automatic t_cache;
    int f, n;
    for (int i = 1; i < 40; i++) fchk(17'h00200 + 17'(i), 1'b0, n);
    f = sff_flash_model_i.frames;
    fchk(17'h00210, 1'b0, n);
    fchk(17'h00211, 1'b0, n);
    chk("hit_cycles", 2, n);
    chk("hit_frames", f, sff_flash_model_i.frames);
    fchk(17'h00207, 1'b0, n);
    chk("evicted", f + 1, sff_flash_model_i.frames);
    fchk(17'h00208, 1'b0, n);
    fchk(17'h00207, 1'b0, n);
    chk("rebased_hit", f + 1, sff_flash_model_i.frames);
  endtask : t_cache

  task automatic t_dual;
    int n;
    wr(OFF_FROP, 32'h3B);
    wr(OFF_CTRL, 32'h2);
    fchk(17'h1ABCD, 1'b1, n);
    fchk(17'h1ABCE, 1'b1, n);
    chk("dual_opcode", 32'h3B, sff_flash_model_i.rx_b[0]);
    chk("dual_high", 32'h01, sff_flash_model_i.rx_b[1]);
    chk("dual_clocks", 48, sff_flash_model_i.bc);
    wr(OFF_CTRL, 32'h0);
  endtask : t_dual

  task automatic t_cmd(input logic [3:0] len, input logic [63:0] v);
    logic [31:0] r;
    logic [7:0] e;
    wr(OFF_LEN, {28'h0, len});
    wr(OFF_CMD0, v[31:0]);
    wr(OFF_CMD1, v[63:32]);
    wr(OFF_CTRL, 32'h1);
    do rd(OFF_STAT, r); while (r[0] !== 1'b0);
    chk("cmd_clocks", 8 * len, sff_flash_model_i.bc);
    chk("cmd_select", 1, flash_select_b_o);
    rd(OFF_CTRL, r);
    chk("go_clear", 0, r[0]);
    for (int i = 0; i < len; i++) begin
      e = (i < 8) ? v[8*i +: 8] : DONT_CARE_BYTE;
      chk("cmd_byte", e, sff_flash_model_i.rx_b[i]);
    end
  endtask : t_cmd

  task automatic t_cmds;
    logic [31:0] r;
    for (int i = 0; i < 3; i++) t_cmd(4'h4, {32'h0, 24'h563412, OPS[i]});
    t_cmd(4'h5, {24'h0, 40'hC7_56_34_12_02});
    for (int i = 3; i < 9; i++) t_cmd(4'h1, {56'h0, OPS[i]});
    t_cmd(4'h4, {56'h0, 8'h9F});
    rd(OFF_RSP0, r);
    chk("ident", 32'h715C3A, r & 32'hFFFFFF);
    t_cmd(4'hA, {32'hF0E1D2C3, 32'hB4A59687});
  endtask : t_cmds

  task automatic t_off;
    int f, n;
    logic [7:0] d;
    wr(OFF_UTIL, 32'h1);
    f = sff_flash_model_i.frames;
    fetch(17'h00300, 1'b0, d, n);
    chk("off_data", DONT_CARE_BYTE, d);
    wr(OFF_LEN, 32'h1);
    wr(OFF_CTRL, 32'h1);
    repeat (40) @(posedge clk_i);
    chk("off_frames", f, sff_flash_model_i.frames);
    wr(OFF_UTIL, 32'h0);
    fchk(17'h00300, 1'b0, n);
    chk("on_frames", f + 1, sff_flash_model_i.frames);
  endtask : t_off

  task automatic close_out;
    if (bad_count == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : close_out

  initial begin
    repeat (80000) @(posedge clk_i);
    bad_count++;
    close_out;
  end

  initial begin
    repeat (2) @(posedge clk_i);
    rst_b_i <= 1'b1;
    t_boot;
    t_seq;
    t_cache;
    t_dual;
    t_cmds;
    t_off;
    close_out;
  end
endmodule : spi_flash_fetch_controller_tb
`default_nettype wire
